// >>> verilog/fgp_pkg.sv
// fgp_pkg: constants for the five-pin gpio port
// assumes a 32-bit apb slave with word-aligned registers
package fgp_pkg;

    // ==========================================================
    // geometry
    localparam int FGP_NPIN = 5;
    localparam int FGP_REGW = 8;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] FGP_OFS_LATCH = 8'h00;
    localparam logic [7:0] FGP_OFS_DIR = 8'h04;
    localparam logic [7:0] FGP_OFS_PULL = 8'h08;
    localparam logic [7:0] FGP_OFS_STBY = 8'h0c;
    localparam logic [7:0] FGP_OFS_PINS = 8'h10;

    // ==========================================================
    // standby control register fields and clock-in pin
    localparam int FGP_STBY_SPL_BIT = 0;
    localparam int FGP_STBY_EXT_IRQ_BIT = 1;
    localparam int FGP_STBY_IRQ_SEL_BIT = 2;
    localparam int FGP_STBY_WIDTH = 3;
    localparam int FGP_CLKIN_PIN = 4;

    // ==========================================================
    // reset values
    localparam logic [4:0] FGP_LATCH_RST = 5'h00;
    localparam logic [4:0] FGP_DIR_RST = 5'h00;
    localparam logic [4:0] FGP_PULL_RST = 5'h00;
    localparam logic [2:0] FGP_STBY_RST = 3'h0;

endpackage : fgp_pkg

// >>> verilog/fgp_port.sv
// fgp_port: five-pin gpio port with apb registers and shared peripherals
// assumes pins and peripheral signals synchronous to pclk; pad resolves
// pin level from pin_o/pin_oe and pull-up from pullup_en
//
// Function
// [RULE1] direction bit 1 makes pin output
// [RULE2] output pin driven from data latch
// [RULE3] latch write always updates, output follows immediately; code updates the latch only when pstrb[0] is set
// [RULE4] output pin read returns latch value
// [RULE5] direction bit 0 makes pin input
// [RULE6] input pin write latched, not driven
// [RULE7] input pin read: pin, rmw: latch
// [RULE8] peripheral output enable overrides port drive
// [RULE9] peripheral output: read pin, rmw latch
// [RULE10] peripheral input: read pin, rmw latch
// [RULE11] software clears direction for peripheral input
// [RULE12] software disables peripheral output for port use
// [RULE13] reset clears all direction bits
// [RULE14] standby with spl forces all pins hi-z
// [RULE15] forced standby blocks input, reads low
// [RULE16] clock-in pin unblocked when its irq enabled
// [RULE17] spl clear keeps pin states in standby
// [RULE18] pull-up bit connects internal pull-up
// [RULE19] low output disconnects pull-up
// [RULE20] bits 0..4 map pins, 5..7 none
// [RULE21] rmw qualifier selects latch on read
//
// Local design decisions: the APB slave port and the register offsets.
module fgp_port
    import fgp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic rmw_read,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] pin_i,
    output logic [4:0] pin_o,
    output logic [4:0] pin_oe,
    output logic [4:0] pullup_en,
    input wire logic standby_req,
    input wire logic pulse_gen_out_a,
    input wire logic pulse_gen_out_b,
    input wire logic composite_timer_out_a,
    input wire logic composite_timer_out_b,
    input wire logic [3:0] periph_oe,
    output logic [4:0] pin_in_to_periph,
    output logic timer_ext_clock_in
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [4:0] latch;
        logic [4:0] dir;
        logic [4:0] pull;
        logic [2:0] stby;
        logic [31:0] rdata;
    } fgp_state_s;

    fgp_state_s st_r;
    fgp_state_s st_nxt;

    // ==========================================================
    // helpers
    // zero-extend a pin field to a bus word
    function automatic logic [31:0] fgp_pad5(input logic [4:0] v);
        fgp_pad5 = {27'h0000000, v};
    endfunction : fgp_pad5

    // zero-extend the standby field to a bus word
    function automatic logic [31:0] fgp_pad3(input logic [2:0] v);
        fgp_pad3 = {29'h00000000, v};
    endfunction : fgp_pad3

    // low pin field of a write word
    function automatic logic [4:0] fgp_field5(input logic [31:0] w);
        fgp_field5 = w[4:0];
    endfunction : fgp_field5

    // low standby field of a write word
    function automatic logic [2:0] fgp_field3(input logic [31:0] w);
        fgp_field3 = w[2:0];
    endfunction : fgp_field3

    // register address match
    function automatic logic fgp_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        fgp_hit = (addr == ofs);
    endfunction : fgp_hit

    // peripheral value wins over the port latch
    function automatic logic fgp_drive_bit(
        input logic per_on,
        input logic per_bit,
        input logic latch_bit
    );
        if (per_on)
        begin
            fgp_drive_bit = per_bit;
        end
        else
        begin
            fgp_drive_bit = latch_bit;
        end
    endfunction : fgp_drive_bit

    // pin driven from the latch by the port itself
    function automatic logic fgp_own_bit(
        input logic dir_bit,
        input logic per_on
    );
        if (per_on)
        begin
            fgp_own_bit = 1'b0;
        end
        else
        begin
            fgp_own_bit = dir_bit;
        end
    endfunction : fgp_own_bit

    // rmw and own-output reads see the latch, others the pin
    function automatic logic fgp_read_bit(
        input logic rmw,
        input logic own_out,
        input logic latch_bit,
        input logic pin_bit
    );
        if (rmw)
        begin
            fgp_read_bit = latch_bit;
        end
        else if (own_out)
        begin
            fgp_read_bit = latch_bit;
        end
        else
        begin
            fgp_read_bit = pin_bit;
        end
    endfunction : fgp_read_bit

    // pull-up drops while the pin drives low
    function automatic logic fgp_pull_bit(
        input logic pull_bit,
        input logic oe_bit,
        input logic val_bit
    );
        if (oe_bit && !val_bit)
        begin
            fgp_pull_bit = 1'b0;
        end
        else
        begin
            fgp_pull_bit = pull_bit;
        end
    endfunction : fgp_pull_bit

    // input gate: closed in forced standby unless clock-in irq is on
    function automatic logic fgp_pass_bit(
        input logic forced_on,
        input logic is_clkin,
        input logic unblock
    );
        if (!forced_on)
        begin
            fgp_pass_bit = 1'b1;
        end
        else if (is_clkin && unblock)
        begin
            fgp_pass_bit = 1'b1;
        end
        else
        begin
            fgp_pass_bit = 1'b0;
        end
    endfunction : fgp_pass_bit

    // ==========================================================
    // pin logic
    logic [4:0] per_val;
    logic [4:0] per_en;
    logic forced;
    logic clk_unblock;
    logic [4:0] in_pass;
    logic [4:0] pin_seen;
    logic [4:0] drive_val;
    logic [4:0] drive_en;
    logic [4:0] pull_on;
    logic [4:0] own_out;
    logic [4:0] data_rd;

    // standby gating of the input path
    always_comb
    begin
        // spl clear leaves pins alone in standby
        forced = standby_req &
                 st_r.stby[FGP_STBY_SPL_BIT]; // [RULE14] [RULE17]
        clk_unblock = st_r.stby[FGP_STBY_EXT_IRQ_BIT] &
                      st_r.stby[FGP_STBY_IRQ_SEL_BIT]; // [RULE16]

        in_pass = 5'h00;
        pin_seen = 5'h00;
        for (int i = 0; i < FGP_NPIN; i++)
        begin
            in_pass[i] = fgp_pass_bit(forced, i == FGP_CLKIN_PIN,
                                      clk_unblock); // [RULE15] [RULE16]
            pin_seen[i] = pin_i[i] & in_pass[i]; // [RULE15]
        end
    end

    // pin drive and pull-up
    always_comb
    begin
        per_val = {1'b0, composite_timer_out_b, composite_timer_out_a,
                   pulse_gen_out_b, pulse_gen_out_a};
        per_en = {1'b0, periph_oe};

        drive_val = 5'h00;
        drive_en = 5'h00;
        pull_on = 5'h00;
        for (int i = 0; i < FGP_NPIN; i++)
        begin
            drive_val[i] = fgp_drive_bit(per_en[i], per_val[i],
                                         st_r.latch[i]); // [RULE2] [RULE8]
            drive_en[i] = (per_en[i] | st_r.dir[i]) &
                          ~forced; // [RULE1] [RULE5] [RULE14]
            pull_on[i] = fgp_pull_bit(st_r.pull[i], drive_en[i],
                                      drive_val[i]); // [RULE18] [RULE19]
        end
    end

    // data register read value per pin
    always_comb
    begin
        own_out = 5'h00;
        data_rd = 5'h00;
        for (int i = 0; i < FGP_NPIN; i++)
        begin
            own_out[i] = fgp_own_bit(st_r.dir[i], per_en[i]); // [RULE9]
            data_rd[i] = fgp_read_bit(rmw_read, own_out[i],
                                      st_r.latch[i], // [RULE4] [RULE7]
                                      pin_seen[i]); // [RULE10] [RULE21]
        end
    end

    assign pin_o = drive_val; // [RULE3] [RULE6]
    assign pin_oe = drive_en;
    assign pullup_en = pull_on;
    assign pin_in_to_periph = pin_seen;
    assign timer_ext_clock_in = pin_seen[FGP_CLKIN_PIN];

    // ==========================================================
    // apb slave, zero wait states
    logic apb_setup;
    logic apb_access;
    logic wr_en;
    logic rd_en;
    logic wr_latch;
    logic wr_dir;
    logic wr_pull;
    logic wr_stby;
    logic [31:0] rd_word;

    always_comb
    begin
        apb_setup = psel & ~penable;
        apb_access = psel & penable;
        wr_en = apb_access & pwrite & pstrb[0];
        rd_en = apb_setup & ~pwrite;

        wr_latch = wr_en & fgp_hit(paddr, FGP_OFS_LATCH);
        wr_dir = wr_en & fgp_hit(paddr, FGP_OFS_DIR);
        wr_pull = wr_en & fgp_hit(paddr, FGP_OFS_PULL);
        wr_stby = wr_en & fgp_hit(paddr, FGP_OFS_STBY);

        // read word loaded at the setup edge
        unique case (paddr)
            FGP_OFS_LATCH:
            begin
                rd_word = fgp_pad5(data_rd);
            end
            FGP_OFS_DIR:
            begin
                rd_word = fgp_pad5(st_r.dir);
            end
            FGP_OFS_PULL:
            begin
                rd_word = fgp_pad5(st_r.pull);
            end
            FGP_OFS_STBY:
            begin
                rd_word = fgp_pad3(st_r.stby);
            end
            FGP_OFS_PINS:
            begin
                rd_word = fgp_pad5(pin_seen);
            end
            default:
            begin
                rd_word = 32'h00000000;
            end
        endcase

        st_nxt = st_r;
        if (wr_latch)
        begin
            st_nxt.latch = fgp_field5(pwdata); // [RULE3] [RULE20]
        end
        if (wr_dir)
        begin
            st_nxt.dir = fgp_field5(pwdata); // [RULE20]
        end
        if (wr_pull)
        begin
            st_nxt.pull = fgp_field5(pwdata);
        end
        if (wr_stby)
        begin
            st_nxt.stby = fgp_field3(pwdata);
        end

        if (rd_en)
        begin
            st_nxt.rdata = rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r.latch <= FGP_LATCH_RST;
            st_r.dir <= FGP_DIR_RST; // [RULE13]
            st_r.pull <= FGP_PULL_RST;
            st_r.stby <= FGP_STBY_RST;
            st_r.rdata <= 32'h00000000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

endmodule : fgp_port

// >>> tb/fgp_port_checker.sv
// fgp_port_checker: port assertions for fgp_port
// bound to fgp_port, one pclk domain
module fgp_port_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic rmw_read,
    input wire logic [31:0] prdata,
    input wire logic [4:0] pin_i,
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pullup_en,
    input wire logic standby_req,
    input wire logic pulse_gen_out_a,
    input wire logic [3:0] periph_oe,
    input wire logic [4:0] pin_in_to_periph
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pins driven by the port itself
    wire [4:0] po = pin_oe & ~{1'b0, periph_oe};
    wire rs = psel && !penable && !pwrite && paddr == 8'h00;
    property p_rst; $rose(presetn) |-> po == 5'h00; endproperty
    a_rst: assert property (p_rst) else $error("pins driven");
    property p_wr; psel && penable && pwrite && paddr == 8'h00 && pstrb[0]
        |=> ((pin_o ^ $past(pwdata[4:0])) & po) == 5'h00; endproperty
    a_wr: assert property (p_wr) else $error("pin not new");
    property p_rd; rs && !rmw_read && !standby_req && po == 5'h00
        |=> prdata[4:0] == $past(pin_i); endproperty
    a_rd: assert property (p_rd) else $error("pin read");
    property p_out; rs |=> ((prdata[4:0] ^ $past(pin_o)) & $past(po)) == 5'h00;
    endproperty
    a_out: assert property (p_out) else $error("latch read");
    property p_hi; psel && penable && !pwrite |-> prdata[31:5] == 27'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("high bits");
    property p_pu; (pullup_en & pin_oe & ~pin_o) == 5'h00; endproperty
    a_pu: assert property (p_pu) else $error("pullup low");
    property p_blk; (pin_in_to_periph & ~pin_i) == 5'h00; endproperty
    a_blk: assert property (p_blk) else $error("input path");
    property p_drv; periph_oe[0] && !standby_req
        |-> pin_oe[0] && pin_o[0] == pulse_gen_out_a; endproperty
    a_drv: assert property (p_drv) else $error("periph out");
endmodule : fgp_port_checker

// >>> tb/fgp_pad.sv
// fgp_pad: pads and outside drivers of the port
// device drive wins; a floating pin wanders
module fgp_pad (
    input wire logic pclk,
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pullup_en,
    input wire logic [4:0] ext_v,
    input wire logic [4:0] ext_oe,
    output logic [4:0] pin_i
);
    logic tg_r = 1'b0;
    always_ff @(posedge pclk) tg_r <= ~tg_r;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_v)
        | (~pin_oe & ~ext_oe & (pullup_en | {5{tg_r}}));
endmodule : fgp_pad

// >>> tb/fgp_port_tb_top.sv
// fgp_port_tb_top: directed bench for fgp_port
// fgp_pad resolves pins; pclk 200 MHz
module fgp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic rmw_read = 0, standby_req = 0, pulse_gen_out_a = 0;
    logic pulse_gen_out_b = 0, composite_timer_out_a = 0;
    logic composite_timer_out_b = 0, timer_ext_clock_in, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h1, periph_oe = 4'h0;
    logic [4:0] pin_i, pin_o, pin_oe, pullup_en, pin_in_to_periph;
    logic [4:0] ext_v = 5'h00, ext_oe = 5'h00;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    fgp_port dut (.*);
    fgp_pad pad (.*);
    task automatic ck(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : ck
    task automatic xf(logic w, logic [7:0] a, logic [31:0] d, logic m = 0);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        rmw_read <= m;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        ck("rdy", pready, 1'b1);
        ck("err", pslverr, 1'b0);
        psel <= 0;
        penable <= 0;
        #1;
    endtask : xf
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        #1;
        ck("oe", pin_oe, 5'h00);
        xf(0, 8'h04, 32'h0);
        ck("dir", rd, 32'h0);
        xf(1, 8'h04, 32'h1f);
        xf(1, 8'h00, 32'h15);
        ck("oe", pin_oe, 5'h1f);
        ck("out", pin_o, 5'h15);
        xf(0, 8'h00, 32'h0);
        ck("latch", rd, 32'h15);
        xf(1, 8'h08, 32'hff);
        ck("pu", pullup_en, 5'h15);
        xf(0, 8'h08, 32'h0);
        ck("pul", rd, 32'h1f);
        $display("output done");
        xf(1, 8'h04, 32'h0);
        ext_oe <= 5'h0e;
        ext_v <= 5'h0a;
        ck("oe", pin_oe, 5'h00);
        ck("pu", pullup_en, 5'h1f);
        xf(1, 8'h00, 32'h04);
        ck("oe", pin_oe, 5'h00);
        xf(0, 8'h00, 32'h0);
        ck("pin", rd, 32'h1b);
        xf(0, 8'h00, 32'h0, 1);
        ck("rmw", rd, 32'h04);
        $display("input done");
        periph_oe <= 4'h1;
        xf(0, 8'h00, 32'h0);
        ck("oe", pin_oe, 5'h01);
        ck("pin", rd, 32'h1a);
        periph_oe <= 4'h0;
        $display("periph done");
        ext_oe <= 5'h1f;
        ext_v <= 5'h10;
        xf(1, 8'h04, 32'h1f);
        xf(1, 8'h0c, 32'h1);
        standby_req <= 1;
        @(posedge pclk);
        #1;
        ck("oe", pin_oe, 5'h00);
        ck("in", pin_in_to_periph, 5'h00);
        xf(1, 8'h0c, 32'h7);
        ck("clk", timer_ext_clock_in, 1'b1);
        xf(1, 8'h0c, 32'h0);
        ck("oe", pin_oe, 5'h1f);
        standby_req <= 0;
        $display("standby done");
        print_verdict();
    end
endmodule : fgp_port_tb_top
bind fgp_port fgp_port_checker chk (.*);
